// ---- src/sac_pkg.sv ----
// Package: register map, field positions and timing for the converter control
// Assumes: 32-bit register port, one aligned word per register
package sac_pkg;
   localparam logic [3:0]  OFF_CONTROL   = 4'h0;
   localparam logic [3:0]  OFF_RESULT    = 4'h4;
   localparam logic [3:0]  OFF_PIN_CFG   = 4'h8;
   localparam logic [3:0]  OFF_IRQ_EN    = 4'hC;
   localparam int          BIT_REF_SEL   = 12;
   localparam int          BIT_ENABLE    = 11;
   localparam int          DIV_HI        = 10;
   localparam int          DIV_LO        = 8;
   localparam int          BIT_RES       = 7;
   localparam int          BIT_START     = 6;
   localparam int          BIT_EOC       = 5;
   localparam int          BIT_GATE      = 4;
   localparam int          CH_HI         = 3;
   localparam int          CH_LO         = 0;
   localparam int          NUM_CH        = 10;
   localparam logic [3:0]  CH_MAX        = 4'h9;
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
   localparam logic [31:0] CONTROL_WMASK = 32'h0000_1FDF;
   localparam int          RES_W         = 12;
   localparam logic [4:0]  STEPS_12      = 5'h10;
   localparam logic [4:0]  STEPS_8       = 5'h0C;
   localparam logic [1:0]  PCLK_PER_STEP = 2'h3;
   localparam logic [3:0]  RES8_LSB      = 4'h4;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONV = 2'b01,
      ST_DONE = 2'b11
   } sac_state_t;
endpackage : sac_pkg

// ---- src/sac_clk_div.sv ----
// Divided converter clock tick generator
// Assumes: divider code stable during a conversion; reserved codes map to /1
`timescale 1ns/1ps
module sac_clk_div (
   input  wire logic       core_clk,
   input  wire logic       arst_n,
   input  wire logic       run,
   input  wire logic [2:0] div_code,
   output logic            tick
);
   logic [4:0] cnt_q;
   logic [4:0] cnt_d;
   logic [4:0] limit;
   logic       tick_d;

   always_comb begin
      unique case (div_code)
         3'b001:  limit = 5'h01;
         3'b010:  limit = 5'h03;
         3'b011:  limit = 5'h07;
         3'b101:  limit = 5'h0F;
         3'b110:  limit = 5'h1F;
         default: limit = 5'h00;
      endcase
      tick_d = run && (cnt_q >= limit);
      if (!run || tick_d) begin
         cnt_d = 5'h00;
      end else begin
         cnt_d = cnt_q + 5'h01;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= 5'h00;
         tick  <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick  <= tick_d;
      end
   end
endmodule : sac_clk_div

// ---- src/sac_chan_mux.sv ----
// Channel gate decode and pin isolation
// Assumes: analog core consumes one-hot channel connect lines
`timescale 1ns/1ps
module sac_chan_mux #(
   parameter int N = 10
) (
   input  wire logic [3:0]   chan,
   input  wire logic         gate_en,
   input  wire logic [N-1:0] pin_cfg,
   output logic [N-1:0]      connect,
   output logic [N-1:0]      isolate
);
   always_comb begin
      for (int i = 0; i < N; i++) begin
         connect[i] = gate_en && (chan == i[3:0]);
         isolate[i] = pin_cfg[i];
      end
   end
endmodule : sac_chan_mux

// ---- src/sac_ctrl.sv ----
// Converter control and result registers with step sequencer
// Assumes: analog core returns a 12-bit code; synchronous register port
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module sac_ctrl #(
   parameter int N_CH = sac_pkg::NUM_CH
) (
   input  wire logic            core_clk,
   input  wire logic            arst_n,
   input  wire logic [3:0]      reg_addr,
   input  wire logic [31:0]     reg_wdata,
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   output logic [31:0]          reg_rdata,
   input  wire logic [11:0]     core_code,
   output logic                 ref_source_select,
   output logic                 converter_enable,
   output logic                 core_sample,
   output logic [N_CH-1:0]      analog_input_connect,
   output logic [N_CH-1:0]      analog_only_isolate,
   output logic                 conversion_irq
);
   logic [31:0]           ctrl_q;
   logic [31:0]           ctrl_d;
   logic [11:0]           result_q;
   logic [11:0]           result_d;
   logic [N_CH-1:0]       pin_cfg_q;
   logic [N_CH-1:0]       pin_cfg_d;
   logic [N_CH-1:0]       irq_en_q;
   logic [N_CH-1:0]       irq_en_d;
   logic [31:0]           rdata_d;
   logic                  irq_d;
   logic                  sample_d;
   logic [1:0]            phase_q;
   logic [1:0]            phase_d;
   logic [4:0]            step_q;
   logic [4:0]            step_d;
   logic [3:0]            conv_ch_q;
   logic [3:0]            conv_ch_d;
   sac_pkg::sac_state_t   state_q;
   sac_pkg::sac_state_t   state_d;
   logic                  tick;
   logic                  running;
   logic [4:0]            steps;
   logic [N_CH-1:0]       connect_w;
   logic [N_CH-1:0]       isolate_w;

   assign running = (state_q == sac_pkg::ST_CONV);

   sac_clk_div u_div (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .run      (running),
      .div_code (ctrl_q[sac_pkg::DIV_HI:sac_pkg::DIV_LO]),
      .tick     (tick)
   );

   sac_chan_mux #(.N(N_CH)) u_mux (
      .chan    (ctrl_q[sac_pkg::CH_HI:sac_pkg::CH_LO]),
      .gate_en (ctrl_q[sac_pkg::BIT_GATE]),
      .pin_cfg (pin_cfg_q),
      .connect (connect_w),
      .isolate (isolate_w)
   );

   always_comb begin
      ctrl_d    = ctrl_q;
      result_d  = result_q;
      pin_cfg_d = pin_cfg_q;
      irq_en_d  = irq_en_q;
      state_d   = state_q;
      phase_d   = phase_q;
      step_d    = step_q;
      conv_ch_d = conv_ch_q;
      irq_d     = 1'b0;
      sample_d  = 1'b0;
      rdata_d   = 32'h0000_0000;
      steps     = ctrl_q[sac_pkg::BIT_RES] ? sac_pkg::STEPS_12
                                           : sac_pkg::STEPS_8;
      if (reg_wr) begin
         unique case (reg_addr)
            sac_pkg::OFF_CONTROL: begin
               // Only writable fields land; end flag kept unless start is written as 1
               ctrl_d = (reg_wdata & sac_pkg::CONTROL_WMASK)
                      | (ctrl_q & ~sac_pkg::CONTROL_WMASK);
               if (reg_wdata[sac_pkg::BIT_START]) begin
                  ctrl_d[sac_pkg::BIT_EOC] = 1'b0;
               end
            end
            sac_pkg::OFF_PIN_CFG: pin_cfg_d = reg_wdata[N_CH-1:0];
            sac_pkg::OFF_IRQ_EN:  irq_en_d  = reg_wdata[N_CH-1:0];
            default: ;
         endcase
      end
      unique case (state_q)
         sac_pkg::ST_IDLE: begin
            // Start needs enable; a disabled core never converts
            if (ctrl_q[sac_pkg::BIT_START] &&
                ctrl_q[sac_pkg::BIT_ENABLE]) begin
               state_d   = sac_pkg::ST_CONV;
               phase_d   = 2'b00;
               step_d    = 5'h00;
               conv_ch_d = ctrl_q[sac_pkg::CH_HI:sac_pkg::CH_LO];
            end
         end
         sac_pkg::ST_CONV: begin
            if (!ctrl_d[sac_pkg::BIT_START] ||
                !ctrl_q[sac_pkg::BIT_ENABLE]) begin
               state_d = sac_pkg::ST_IDLE;
            end else if (tick) begin
               phase_d = phase_q + 2'b01;
               if (phase_q == sac_pkg::PCLK_PER_STEP) begin
                  step_d = step_q + 5'h01;
                  if (step_q == steps - 5'h01) begin
                     state_d  = sac_pkg::ST_DONE;
                     sample_d = 1'b1;
                  end
               end
            end
         end
         sac_pkg::ST_DONE: begin
            // Straight binary code; 8-bit mode keeps the top byte
            result_d = core_code;
            if (!ctrl_q[sac_pkg::BIT_RES]) begin
               result_d = {core_code[11:4], sac_pkg::RES8_LSB - 4'h4};
            end
            ctrl_d[sac_pkg::BIT_START] = 1'b0;
            ctrl_d[sac_pkg::BIT_EOC]   = 1'b1;
            if (conv_ch_q <= sac_pkg::CH_MAX) begin
               irq_d = irq_en_q[conv_ch_q];
            end
            state_d = sac_pkg::ST_IDLE;
         end
         default: state_d = sac_pkg::ST_IDLE;
      endcase
      if (reg_rd) begin
         unique case (reg_addr)
            sac_pkg::OFF_CONTROL: rdata_d = ctrl_q;
            sac_pkg::OFF_RESULT:  rdata_d = {20'h0_0000, result_q};
            sac_pkg::OFF_PIN_CFG: rdata_d = {{(32-N_CH){1'b0}}, pin_cfg_q};
            sac_pkg::OFF_IRQ_EN:  rdata_d = {{(32-N_CH){1'b0}}, irq_en_q};
            default:              rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q               <= sac_pkg::CONTROL_RESET;
         pin_cfg_q            <= '0;
         irq_en_q             <= '0;
         state_q              <= sac_pkg::ST_IDLE;
         phase_q              <= 2'b00;
         step_q               <= 5'h00;
         conv_ch_q            <= 4'h0;
         reg_rdata            <= 32'h0000_0000;
         conversion_irq       <= 1'b0;
         core_sample          <= 1'b0;
         ref_source_select    <= 1'b0;
         converter_enable     <= 1'b0;
         analog_input_connect <= '0;
         analog_only_isolate  <= '0;
      end else begin
         ctrl_q               <= ctrl_d;
         pin_cfg_q            <= pin_cfg_d;
         irq_en_q             <= irq_en_d;
         state_q              <= state_d;
         phase_q              <= phase_d;
         step_q               <= step_d;
         conv_ch_q            <= conv_ch_d;
         reg_rdata            <= rdata_d;
         conversion_irq       <= irq_d;
         core_sample          <= sample_d;
         ref_source_select    <= ctrl_q[sac_pkg::BIT_REF_SEL];
         converter_enable     <= ctrl_q[sac_pkg::BIT_ENABLE];
         analog_input_connect <= connect_w;
         analog_only_isolate  <= isolate_w;
      end
   end

   // Result has no reset: its content is undefined until a conversion
   always_ff @(posedge core_clk) begin
      result_q <= result_d;
   end
endmodule : sac_ctrl

// ---- tb/sac_ctrl_monitor.sv ----
// Checker: port properties of the converter control block
// Assumes: bound into sac_ctrl, one clock domain
`timescale 1ns/1ps
module sac_mon #(
   parameter int N_CH = 10
) (
   input wire logic            core_clk,
   input wire logic            arst_n,
   input wire logic [3:0]      reg_addr,
   input wire logic [31:0]     reg_wdata,
   input wire logic            reg_wr,
   input wire logic            reg_rd,
   input wire logic [31:0]     reg_rdata,
   input wire logic            ref_source_select,
   input wire logic            converter_enable,
   input wire logic            core_sample,
   input wire logic [N_CH-1:0] analog_input_connect,
   input wire logic [N_CH-1:0] analog_only_isolate,
   input wire logic            conversion_irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   wire cw = reg_wr && reg_addr == sac_pkg::OFF_CONTROL;
   rd_slot_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
      else $error("read data outside slot");
   unmapped_rd_a: assert property (reg_rd && reg_addr[1:0] != 2'h0
      |=> reg_rdata == '0) else $error("unmapped read not zero");
   ref_follow_a: assert property (cw
      |-> ##2 ref_source_select == $past(reg_wdata[12], 2))
      else $error("reference select lost");
   en_follow_a: assert property (cw
      |-> ##2 converter_enable == $past(reg_wdata[11], 2))
      else $error("enable lost");
   iso_follow_a: assert property (reg_wr
      && reg_addr == sac_pkg::OFF_PIN_CFG
      |-> ##2 analog_only_isolate == $past(reg_wdata[N_CH-1:0], 2))
      else $error("isolate lost");
   gate_off_a: assert property (cw && !reg_wdata[4]
      |-> ##2 analog_input_connect == '0) else $error("gate leak");
   chan_onehot_a: assert property ($onehot0(analog_input_connect))
      else $error("two channels connected");
   no_early_end_a: assert property (cw && reg_wdata[6]
      |=> !core_sample [*8]) else $error("conversion too short");
   irq_end_a: assert property (conversion_irq
      |-> core_sample || $past(core_sample) || $past(core_sample, 2))
      else $error("irq without conversion end");
   cover property (conversion_irq);
   cover property (core_sample);
   cover property (reg_rd && reg_addr == sac_pkg::OFF_RESULT);
endmodule : sac_mon
bind sac_ctrl sac_mon #(.N_CH(N_CH)) sac_mon_i (.core_clk(core_clk),
   .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .ref_source_select(ref_source_select),
   .converter_enable(converter_enable), .core_sample(core_sample),
   .analog_input_connect(analog_input_connect),
   .analog_only_isolate(analog_only_isolate),
   .conversion_irq(conversion_irq));

// ---- tb/sac_core_model.sv ----
// Model: analog core, fixed code per connected channel
// Assumes: one-hot connect lines
`timescale 1ns/1ps
module sac_core (
   input  wire logic       core_clk,
   input  wire logic [9:0] analog_input_connect,
   output logic [11:0]     core_code
);
   logic [11:0] last_q = 12'h000;
   always_ff @(posedge core_clk) last_q <= core_code;
   always_comb begin
      // Open input flips each cycle, never a stale level
      core_code = ~last_q;
      for (int k = 0; k < 10; k++) begin
         // Pin taken as plain input, no pull-up loading the level
         if (analog_input_connect[k]) begin
            core_code = k == 0 ? 12'h000 : k == 9 ? 12'hFFF : {4'(k), 8'hA5};
         end
      end
   end
endmodule : sac_core

// ---- tb/tb_top.sv ----
// Bench: registers, channels and conversions of the control block
// Assumes: sac_core answers on the analog side
`timescale 1ns/1ps
module tb_top;
   logic        core_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata, d;
   logic [11:0] core_code;
   logic        ref_sel, conv_en, smp, irq;
   logic [9:0]  con, iso;
   int          failures = 0, checks = 0, cyc = 0, irqs = 0;
   sac_ctrl sac_ctrl_i (.core_clk(core_clk), .arst_n(arst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_code(core_code),
      .ref_source_select(ref_sel), .converter_enable(conv_en),
      .core_sample(smp), .analog_input_connect(con),
      .analog_only_isolate(iso), .conversion_irq(irq));
   sac_core sac_core_i (.core_clk(core_clk),
      .analog_input_connect(con), .core_code(core_code));
   initial forever #25 core_clk = ~core_clk;
   task automatic end_of_test;
      if (failures == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_of_test
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (irq === 1'b1) irqs <= irqs + 1;
      if (cyc == 20000) begin
         failures++;
         end_of_test();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic chk_rng(input int g, input int lo, input int hi);
      checks++;
      if (g < lo || g > hi) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, g, lo);
      end
   endtask : chk_rng
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic t_regs;
      rd(sac_pkg::OFF_CONTROL);
      chk(d, 32'h0000_0000);
      rd(4'h2);
      chk(d, 32'h0000_0000);
      wr(sac_pkg::OFF_CONTROL, 32'hFFFF_FFBF);
      rd(sac_pkg::OFF_CONTROL);
      chk(d, 32'h0000_1F9F);
      chk({30'h0, ref_sel, conv_en}, 32'h0000_0003);
      chk({22'h0, con}, 32'h0000_0000);
      wr(sac_pkg::OFF_PIN_CFG, 32'hFFFF_F2A5);
      rd(sac_pkg::OFF_PIN_CFG);
      chk({22'h0, iso}, 32'h0000_02A5);
   endtask : t_regs
   task automatic t_chans;
      for (int c = 0; c < 10; c++) begin
         wr(sac_pkg::OFF_CONTROL, 32'h0000_0010 | c);
         repeat (3) @(posedge core_clk);
         chk({22'h0, con}, 32'h0000_0001 << c);
      end
      wr(sac_pkg::OFF_CONTROL, 32'h0000_0003);
      repeat (3) @(posedge core_clk);
      chk({22'h0, con}, 32'h0000_0000);
   endtask : t_chans
   task automatic t_held;
      wr(sac_pkg::OFF_IRQ_EN, 32'h0000_0008);
      wr(sac_pkg::OFF_CONTROL, 32'h0000_0053);
      repeat (100) @(posedge core_clk);
      rd(sac_pkg::OFF_CONTROL);
      chk(d, 32'h0000_0053);
      wr(sac_pkg::OFF_CONTROL, 32'h0000_0800);
      repeat (2000) @(posedge core_clk);
      rd(sac_pkg::OFF_CONTROL);
      chk(d, 32'h0000_0800);
   endtask : t_held
   task automatic t_conv;
      int n, t0, b;
      logic [2:0] dc;
      logic [3:0] ch;
      logic [11:0] lv;
      logic r;
      for (int k = 0; k < 6; k++) begin
         b = (k % 2 ? 48 : 64) << k;
         r = (k % 2 == 0);
         dc = 3'(k < 4 ? k : k + 1);
         ch = 4'(k == 0 ? 3 : k == 1 ? 0 : k < 4 ? 9 : k == 4 ? 5 : 1);
         lv = ch == 0 ? 12'h000 : ch == 9 ? 12'hFFF : {ch, 8'hA5};
         t0 = cyc;
         wr(sac_pkg::OFF_CONTROL, {19'h0, 2'b01, dc, r, 3'b101, ch});
         n = 0;
         do begin
            rd(sac_pkg::OFF_CONTROL);
            n++;
         end while (d[5] !== 1'b1 && n < 1500);
         chk_rng(cyc - t0, b - (1 << k), b + (1 << k) + 12);
         chk(d, {19'h0, 2'b01, dc, r, 3'b011, ch});
         rd(sac_pkg::OFF_RESULT);
         chk(d, {20'h0, r ? lv : {lv[11:4], 4'h0}});
         chk(d >> 4, {24'h0, lv[11:4]});
      end
      chk(32'(irqs), 32'h0000_0001);
   endtask : t_conv
   task automatic t_ignore;
      wr(sac_pkg::OFF_RESULT, 32'h0000_0123);
      rd(sac_pkg::OFF_RESULT);
      chk(d, 32'h0000_01A0);
      wr(sac_pkg::OFF_CONTROL, 32'h0000_0800);
      rd(sac_pkg::OFF_CONTROL);
      chk(d, 32'h0000_0820);
   endtask : t_ignore
   initial begin
      repeat (6) @(posedge core_clk);
      arst_n <= 1'b1;
      t_regs();
      t_chans();
      t_held();
      t_conv();
      t_ignore();
      end_of_test();
   end
endmodule : tb_top
